/* File: design/ipr_irq_router.sv */
// ------------------------------------------------------------
// ------------------------------------------------------------
module ipr_irq_router
   import ipr_pkg::*;
(
   input  wire logic        clk_sys,     // System clock, 25 MHz
   input  wire logic        sys_rst,     // Synchronous reset
   input  wire logic        hsel,        // AHB slave select
   input  wire logic [31:0] haddr,       // AHB address
   input  wire logic [1:0]  htrans,      // AHB transfer type
   input  wire logic        hwrite,      // AHB write
   input  wire logic [2:0]  hsize,       // AHB size, word only
   input  wire logic [31:0] hwdata,      // AHB write data
   input  wire logic        hready,      // AHB bus ready
   output logic             hreadyout,   // AHB slave ready
   output logic             hresp,       // AHB response, OKAY
   output logic [31:0]      hrdata,      // AHB read data
   input  wire logic [7:0]  featEvt,     // Feature engine events
   input  wire logic [2:0]  hwEvt,       // Full, level, sample ready
   input  wire logic        irqPinAIn,   // Pin A pad input
   output logic             irqPinAOut,  // Pin A pad output
   output logic             irqPinAOe,   // Pin A output enable
   input  wire logic        irqPinBIn,   // Pin B pad input
   output logic             irqPinBOut,  // Pin B pad output
   output logic             irqPinBOe,   // Pin B output enable
   output logic             irqOut       // Summary interrupt, level
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic              rdy;
      logic [31:0]       rdata;
      logic              pend;
      logic              wr;
      logic [7:0]        idx;
      logic              hit;
      logic [CFG_W-1:0]  cfgA;
      logic [CFG_W-1:0]  cfgB;
      logic              hold;
      logic [7:0]        mapA;
      logic [7:0]        mapB;
      logic [7:0]        hwMap;
      logic [STAT_W-1:0] stat;
      logic [STAT_W-1:0] mask;
      logic              actA;
      logic              actB;
      logic              irq;
   } ipr_top_st_t;

   ipr_top_st_t       st_q, st_d;
   logic              takeAddr;
   logic              rdStat;
   logic              srcA;
   logic              srcB;
   logic              trigA;
   logic              trigB;
   logic [STAT_W-1:0] setBits;
   logic [31:0]       rdMux;

   // ------------------------------------------------------------
   // Event routing
   // ------------------------------------------------------------
   // Step bit carries watermark or step detect; activity bit carries
   // a change among running, walking and still
   // Reserved route bits are never stored, so they cannot route
   assign srcA = |(featEvt & st_q.mapA)
               | |(hwEvt & st_q.hwMap[HW_A_LSB +: HW_W]);
   assign srcB = |(featEvt & st_q.mapB)
               | |(hwEvt & st_q.hwMap[HW_B_LSB +: HW_W]);

   // Everything that may set a sticky status bit this cycle
   assign setBits = {trigB, trigA, hwEvt, featEvt & FEAT_VALID};

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Address phase taken only while the bus is ready
   assign takeAddr = hsel & hready & htrans[1];

   // A status read in its data phase clears what it returns
   assign rdStat = st_q.pend & ~st_q.wr & st_q.hit
                 & (st_q.idx == IDX_EVT_STATUS);

   // Read data selection; reserved and unmapped bits read zero
   always_comb begin
      rdMux = RST_RDATA;
      case (st_q.idx)
         IDX_PIN_A_CFG:   rdMux[CFG_W-1:0]  = st_q.cfgA;
         IDX_PIN_B_CFG:   rdMux[CFG_W-1:0]  = st_q.cfgB;
         IDX_HOLD_CFG:    rdMux[HOLD_BIT]   = st_q.hold;
         IDX_PIN_A_ROUTE: rdMux[7:0]        = st_q.mapA;
         IDX_PIN_B_ROUTE: rdMux[7:0]        = st_q.mapB;
         IDX_HW_ROUTE:    rdMux[7:0]        = st_q.hwMap;
         IDX_EVT_STATUS:  rdMux[STAT_W-1:0] = st_q.stat;
         IDX_EVT_MASK:    rdMux[STAT_W-1:0] = st_q.mask;
         IDX_PIN_STATE:   rdMux[1:0]        = {st_q.actB, st_q.actA};
         default:         rdMux             = RST_RDATA;
      endcase
      if (!st_q.hit) begin
         rdMux = RST_RDATA;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;

      // Bus slave: one wait state so read data comes from a flop
      if (st_q.pend) begin
         st_d.pend  = 1'b0;
         st_d.rdy   = 1'b1;
         st_d.rdata = rdMux;
      end else if (takeAddr) begin
         st_d.pend = 1'b1;
         st_d.rdy  = 1'b0;
         st_d.wr   = hwrite;
         st_d.idx  = haddr[9:2];
         st_d.hit  = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
      end

      // Register writes land in the data phase, low byte lanes used
      if (st_q.pend && st_q.wr && st_q.hit) begin
         case (st_q.idx)
            IDX_PIN_A_CFG:   st_d.cfgA  = hwdata[CFG_W-1:0];
            IDX_PIN_B_CFG:   st_d.cfgB  = hwdata[CFG_W-1:0];
            IDX_HOLD_CFG:    st_d.hold  = hwdata[HOLD_BIT];
            IDX_PIN_A_ROUTE: st_d.mapA  = hwdata[7:0] & FEAT_VALID;
            IDX_PIN_B_ROUTE: st_d.mapB  = hwdata[7:0] & FEAT_VALID;
            IDX_HW_ROUTE:    st_d.hwMap = hwdata[7:0] & HW_VALID;
            IDX_EVT_MASK:    st_d.mask  = hwdata[STAT_W-1:0] & {5'h1f, FEAT_VALID};
            default:         st_d.mask  = st_q.mask;
         endcase
      end

      // Sticky status: a new event wins over the read that clears it
      if (rdStat) begin
         st_d.stat = (st_q.stat & ~st_q.stat) | setBits;
      end else begin
         st_d.stat = st_q.stat | setBits;
      end

      // Latched mode keeps an asserted pin until the status read
      if (st_q.hold) begin
         st_d.actA = (st_q.actA & ~rdStat) | srcA;
         st_d.actB = (st_q.actB & ~rdStat) | srcB;
      end else begin
         st_d.actA = srcA;
         st_d.actB = srcB;
      end

      // Summary interrupt, high while an unmasked status bit is set
      st_d.irq = |(st_d.stat & st_q.mask);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   // Every control field resets to zero, matching the printed values
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_q       <= '0;
         st_q.rdy   <= 1'b1;
         st_q.rdata <= RST_RDATA;
         st_q.stat  <= RST_STAT;
         st_q.mask  <= RST_STAT;
         st_q.mapA  <= RST_REG8;
         st_q.mapB  <= RST_REG8;
         st_q.hwMap <= RST_REG8;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   // Pin A conversion
   ipr_pin_ctrl u_pin_a (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .cfg     (st_q.cfgA),
      .active  (st_q.actA),
      .pinIn   (irqPinAIn),
      .pinOut  (irqPinAOut),
      .pinOe   (irqPinAOe),
      .pinTrig (trigA)
   );

   // Pin B conversion
   ipr_pin_ctrl u_pin_b (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .cfg     (st_q.cfgB),
      .active  (st_q.actB),
      .pinIn   (irqPinBIn),
      .pinOut  (irqPinBOut),
      .pinOe   (irqPinBOe),
      .pinTrig (trigB)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign hreadyout = st_q.rdy;
   assign hresp     = 1'b0;
   assign hrdata    = st_q.rdata;
   assign irqOut    = st_q.irq;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Checks sleep through reset, where $past
   // would only see the cleared state
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence seqRouteA;
      (featEvt & st_q.mapA) != 8'h00;
   endsequence

   sequence seqHeldAfter;
      st_q.hold && st_q.actA && !rdStat;
   endsequence

   AST_FEATURE_TO_A: assert property (seqRouteA |=> st_q.actA)
      else $error("routed feature event missed pin A");
   AST_FEATURE_TO_B: assert property (((featEvt & st_q.mapB) != 8'h00) |=> st_q.actB)
      else $error("routed feature event missed pin B");
   AST_HW_TO_A: assert property ((hwEvt & st_q.hwMap[2:0]) != 3'h0 |=> st_q.actA)
      else $error("hardware event missed pin A");
   AST_HW_TO_B: assert property ((hwEvt & st_q.hwMap[6:4]) != 3'h0 |=> st_q.actB)
      else $error("hardware event missed pin B");
   AST_LATCH_KEEPS: assert property (seqHeldAfter |=> st_q.actA)
      else $error("latched pin A dropped without clear");
   AST_NONLATCH_FOLLOWS: assert property (!st_q.hold |=> st_q.actB == $past(srcB))
      else $error("non-latched pin B did not follow its sources");
   AST_RESERVED_ROUTE: assert property (st_q.mapA[0] == 1'b0 && st_q.mapA[4] == 1'b0 && !st_q.hwMap[7])
      else $error("reserved route bit stored");
   AST_CFG_READBACK: assert property (
         st_q.pend && !st_q.wr && st_q.hit && st_q.idx == IDX_PIN_B_CFG
         |=> hreadyout && hrdata == {27'h0000000, $past(st_q.cfgB)})
      else $error("pin B control read back wrong");
   AST_READ_ONE_WAIT: assert property (takeAddr && !st_q.pend |=> !hreadyout ##1 hreadyout)
      else $error("bus answer not after one wait state");

   // Hit data phases, write and read
   sequence seqWrPhase;
      st_q.pend && st_q.wr && st_q.hit;
   endsequence

   sequence seqRdPhase;
      st_q.pend && !st_q.wr && st_q.hit;
   endsequence

   // Writes show one edge after the data phase
   AST_HOLD_WRITE: assert property (seqWrPhase ##0 (st_q.idx == IDX_HOLD_CFG)
         |=> st_q.hold == $past(hwdata[HOLD_BIT]))
      else $error("hold bit write lost");

   // Pin A control keeps the pin B layout
   AST_PIN_A_CFG_WRITE: assert property (seqWrPhase ##0 (st_q.idx == IDX_PIN_A_CFG)
         |=> st_q.cfgA == $past(hwdata[CFG_W-1:0]))
      else $error("pin A control write lost");

   // Reserved hardware route bits dropped
   AST_HW_ROUTE_WRITE: assert property (seqWrPhase ##0 (st_q.idx == IDX_HW_ROUTE)
         |=> st_q.hwMap == ($past(hwdata[7:0]) & HW_VALID))
      else $error("hardware route write wrong");

   // Status reads back as it stood before
   // the clear; later events show next time
   AST_STATUS_READBACK: assert property (seqRdPhase ##0 (st_q.idx == IDX_EVT_STATUS)
         |=> hrdata == {19'h00000, $past(st_q.stat)})
      else $error("status read back wrong");

   // Misses read zero, so software never
   // mistakes a bad address for a register
   AST_UNMAPPED_READ_ZERO: assert property (st_q.pend && !st_q.wr && !st_q.hit |=> hrdata == RST_RDATA)
      else $error("unmapped read not zero");

   // No error path, so masters need no retry
   AST_RESP_OKAY: assert property (hresp == 1'b0)
      else $error("response not okay");

   // Exactly one wait state, whatever the
   // bus offers during it
   AST_ONE_WAIT_ONLY: assert property (st_q.pend |=> !st_q.pend && hreadyout)
      else $error("second wait state");

   // Step event on pin A
   AST_STEP_ROUTE: assert property (featEvt[1] && st_q.mapA[1] |=> st_q.actA)
      else $error("step event missed pin A");

   // Non-latched pin A tracks its sources
   AST_NONLATCH_A_FOLLOWS: assert property (!st_q.hold |=> st_q.actA == $past(srcA))
      else $error("pin A did not follow");

   // Latched pin B held until a status read
   AST_LATCH_B_KEEPS: assert property (st_q.hold && st_q.actB && !rdStat |=> st_q.actB)
      else $error("latched pin B dropped");

   // The status read drops a quiet latch;
   // a still active source keeps it up
   AST_LATCH_CLEARS: assert property (st_q.hold && rdStat && !srcA |=> !st_q.actA)
      else $error("latched pin A not cleared");

   // A new event beats the clearing read,
   // so no edge is lost between read and clear
   AST_STATUS_SET_WINS: assert property (setBits != RST_STAT |=> (st_q.stat & $past(setBits)) == $past(setBits))
      else $error("status event lost");

   // A quiet read leaves every flag clear
   AST_STATUS_CLEARED: assert property (rdStat && setBits == RST_STAT |=> st_q.stat == RST_STAT)
      else $error("status not cleared");

   // Unmasked flag not being read away
   // keeps the summary output up
   AST_IRQ_RAISED: assert property (!rdStat && (st_q.stat & st_q.mask) != RST_STAT |=> irqOut)
      else $error("interrupt missing");

   // Nothing set or arriving: no interrupt
   AST_IRQ_QUIET: assert property (st_q.stat == RST_STAT && setBits == RST_STAT |=> !irqOut)
      else $error("interrupt with no status");

endmodule

/* File: design/ipr_pin_ctrl.sv */
// Electrical handling of one interrupt pin: polarity, drive style,
// output enable, and the optional input path with its trigger style.
module ipr_pin_ctrl
   import ipr_pkg::*;
(
   input  wire logic             clk_sys,  // System clock
   input  wire logic             sys_rst,  // Synchronous reset
   input  wire logic [CFG_W-1:0] cfg,      // Pin control field
   input  wire logic             active,   // Routed interrupt asserted
   input  wire logic             pinIn,    // Pad level, asynchronous
   output logic                  pinOut,   // Pad output value
   output logic                  pinOe,    // Pad output enable
   output logic                  pinTrig   // Input trigger seen
);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic out;
      logic oe;
      logic trig;
   } ipr_pin_st_t;

   ipr_pin_st_t st_q, st_d;
   logic        level;
   logic        atActive;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // Polarity picks the electrical level of an asserted interrupt
   assign level    = cfg[CFG_POL] ? active : ~active;
   assign atActive = (st_q.sync2 == cfg[CFG_POL]);

   always_comb begin
      st_d       = st_q;
      // Two stages before anything looks at the pad
      st_d.sync1 = pinIn;
      st_d.sync2 = st_q.sync1;
      st_d.prev  = st_q.sync2;
      // Open drain only ever pulls low, so it drives when level is 0
      if (cfg[CFG_DRAIN]) begin
         st_d.out = 1'b0;
         st_d.oe  = cfg[CFG_OEN] & ~level;
      end else begin
         st_d.out = level;
         st_d.oe  = cfg[CFG_OEN];
      end
      // Input path silent unless enabled; level or edge trigger
      if (!cfg[CFG_IEN]) begin
         st_d.trig = 1'b0;
      end else if (cfg[CFG_TRIG]) begin
         st_d.trig = atActive & (st_q.prev != cfg[CFG_POL]);
      end else begin
         st_d.trig = atActive;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pinOut  = st_q.out;
   assign pinOe   = st_q.oe;
   assign pinTrig = st_q.trig;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   AST_PUSH_PULL_DRIVE: assert property (!cfg[CFG_DRAIN] && cfg[CFG_OEN] |=> pinOe && pinOut == $past(level))
      else $error("push-pull pin not driving its level");
   AST_DRAIN_NEVER_HIGH: assert property (cfg[CFG_DRAIN] |=> !pinOut && (pinOe == $past(cfg[CFG_OEN] & ~level)))
      else $error("open drain pin drove wrongly");
   AST_OUTPUT_OFF: assert property (!cfg[CFG_OEN] |=> !pinOe)
      else $error("pin driven with output disabled");
   AST_INPUT_OFF: assert property (!cfg[CFG_IEN] |=> !pinTrig)
      else $error("trigger seen with input disabled");
   AST_EDGE_ONCE: assert property (cfg[CFG_TRIG] && $stable(cfg) && pinTrig |=> !pinTrig)
      else $error("edge trigger lasted two cycles");

endmodule

/* File: design/ipr_pkg.sv */
package ipr_pkg;

   // ------------------------------------------------------------
   // Register indexes (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_PIN_A_CFG    = 8'h53;
   localparam logic [7:0] IDX_PIN_B_CFG    = 8'h54;
   localparam logic [7:0] IDX_HOLD_CFG     = 8'h55;
   localparam logic [7:0] IDX_PIN_A_ROUTE  = 8'h56;
   localparam logic [7:0] IDX_PIN_B_ROUTE  = 8'h57;
   localparam logic [7:0] IDX_HW_ROUTE     = 8'h58;
   localparam logic [7:0] IDX_EVT_STATUS   = 8'h60;
   localparam logic [7:0] IDX_EVT_MASK     = 8'h61;
   localparam logic [7:0] IDX_PIN_STATE    = 8'h62;

   // ------------------------------------------------------------
   // Pin control field positions
   // ------------------------------------------------------------
   localparam int CFG_TRIG  = 0;
   localparam int CFG_POL   = 1;
   localparam int CFG_DRAIN = 2;
   localparam int CFG_OEN   = 3;
   localparam int CFG_IEN   = 4;
   localparam int CFG_W     = 5;
   localparam int HOLD_BIT  = 0;

   // ------------------------------------------------------------
   // Routing layouts and writable bits
   // ------------------------------------------------------------
   localparam logic [7:0] FEAT_VALID = 8'hee;
   localparam logic [7:0] HW_VALID   = 8'h77;
   localparam int HW_A_LSB   = 0;
   localparam int HW_B_LSB   = 4;
   localparam int HW_W       = 3;

   // ------------------------------------------------------------
   // Event status layout
   // ------------------------------------------------------------
   localparam int STAT_HW_LSB = 8;
   localparam int STAT_PIN_A  = 11;
   localparam int STAT_PIN_B  = 12;
   localparam int STAT_W      = 13;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  RST_REG8  = 8'h00;
   localparam logic [12:0] RST_STAT  = 13'h0000;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;

endpackage

/* File: dv/ipr_host_model.sv */
// ------------------------------------------------------------
// Host side of the two interrupt wires
// ------------------------------------------------------------
module ipr_host_model (
   input  wire logic aOut,      // Pin A value from the device
   input  wire logic aOe,       // Pin A device drive enable
   input  wire logic bOut,      // Pin B value from the device
   input  wire logic bOe,       // Pin B device drive enable
   input  wire logic hostDrvA,  // Host drives pin A
   input  wire logic hostDrvB,  // Host drives pin B
   input  wire logic hostLvlA,  // Host level on pin A
   input  wire logic hostLvlB,  // Host level on pin B
   output logic      padA,      // Resolved pin A wire
   output logic      padB       // Resolved pin B wire
);
   // Released wires float up through the board pull-up, so open drain reads high
   assign padA = aOe ? aOut : (hostDrvA ? hostLvlA : 1'b1);
   assign padB = bOe ? bOut : (hostDrvB ? hostLvlB : 1'b1);
endmodule

/* File: dv/irq_pin_config_and_routing_tb_top.sv */
module irq_pin_config_and_routing_tb_top
   import ipr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [2:0]  hwEvt = 3'h0;
   logic [7:0]  featEvt = 8'h0;
   logic        hostDrvA = 1'b0;
   logic        hostDrvB = 1'b0;
   logic        hostLvlA = 1'b0;
   logic        hostLvlB = 1'b0;
   logic [31:0] hrdata;
   logic [31:0] rdv;
   logic        hreadyout, hresp, aOut, aOe, bOut, bOe, irqOut, padA, padB;
   int          badCount = 0;
   int          nCompared = 0;

   always #20 clk_sys = ~clk_sys;

   ipr_irq_router dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .featEvt(featEvt), .hwEvt(hwEvt),
      .irqPinAIn(padA), .irqPinAOut(aOut), .irqPinAOe(aOe), .irqPinBIn(padB),
      .irqPinBOut(bOut), .irqPinBOe(bOe), .irqOut(irqOut));

   ipr_host_model host_u (.aOut(aOut), .aOe(aOe), .bOut(bOut), .bOe(bOe), .hostDrvA(hostDrvA),
      .hostDrvB(hostDrvB), .hostLvlA(hostLvlA), .hostLvlB(hostLvlB), .padA(padA), .padB(padB));

   // ------------------------------------------------------------
   // Shared bus, wait and compare tasks
   // ------------------------------------------------------------
   task automatic results();
      $display("compared %0d, mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      nCompared++;
      if (seen !== exp) begin
         badCount++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Bounded wait for hready sampled high; a stuck slave ends the run
   task automatic waitRdy();
      int i;
      i = 0;
      do begin
         @(posedge clk_sys);
         i++;
      end while (hreadyout !== 1'b1 && i < 20);
      if (hreadyout !== 1'b1) begin
         badCount++;
         $display("mismatch at %0t: bus wait timed out", $time);
         results();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitRdy();
      rdv = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rd(input logic [7:0] idx);
      bus(1'b0, idx, 32'h0);
   endtask

   task automatic pulse(input logic [7:0] b);
      featEvt <= b;
      @(posedge clk_sys);
      featEvt <= 8'h0;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic reg_access();
      logic [7:0]  idxT[8] = '{IDX_PIN_A_CFG, IDX_PIN_B_CFG, IDX_HOLD_CFG, IDX_PIN_A_ROUTE,
                               IDX_PIN_B_ROUTE, IDX_HW_ROUTE, IDX_EVT_MASK, 8'h70};
      logic [31:0] mT[8] = '{32'h1f, 32'h1f, 32'h1, 32'hee, 32'hee, 32'h77, 32'h1fee, 32'h0};
      rd(IDX_PIN_STATE);
      chk(rdv, 32'h0, "pin state reset");
      chk({31'h0, hresp}, 32'h0, "okay response");
      for (int i = 0; i < 8; i++) begin
         rd(idxT[i]);
         chk(rdv, 32'h0, "reset value");
         wr(idxT[i], 32'hffff_ffff);
         rd(idxT[i]);
         chk(rdv, mT[i], "writable bits");
         wr(idxT[i], 32'h0);
      end
      $display("test reg_access done");
   endtask

   task automatic feat_route();
      logic [7:0] b;
      wr(IDX_PIN_A_CFG, 32'h0a);
      wr(IDX_PIN_B_CFG, 32'h0a);
      for (int k = 1; k < 8; k++) begin
         if (k == 4) continue;
         b = 8'h1 << k;
         wr(IDX_PIN_A_ROUTE, {24'h0, b});
         wr(IDX_PIN_B_ROUTE, {24'h0, b ^ 8'hee});
         featEvt <= b;
         cyc(4);
         chk({30'h0, aOut, bOut}, 32'h2, "feature to pin A");
         rd(IDX_PIN_STATE);
         chk(rdv, 32'h1, "pin state");
         featEvt <= b ^ 8'hee;
         cyc(4);
         chk({30'h0, aOut, bOut}, 32'h1, "feature to pin B");
         featEvt <= 8'h0;
      end
      wr(IDX_PIN_A_ROUTE, 32'hee);
      featEvt <= 8'h11;
      cyc(4);
      chk({30'h0, aOut, bOut}, 32'h0, "reserved feature bits");
      featEvt <= 8'h0;
      $display("test feat_route done");
   endtask

   task automatic hw_route();
      for (int j = 0; j < 3; j++) begin
         wr(IDX_HW_ROUTE, {24'h0, (8'h1 << j) | (8'h10 << ((j + 1) % 3))});
         hwEvt <= 3'h1 << j;
         cyc(4);
         chk({30'h0, aOut, bOut}, 32'h2, "hw event to pin A");
         hwEvt <= 3'h1 << ((j + 1) % 3);
         cyc(4);
         chk({30'h0, aOut, bOut}, 32'h1, "hw event to pin B");
         hwEvt <= 3'h0;
      end
      $display("test hw_route done");
   endtask

   // Each row: control value, {drive enable, wire} asserted, then idle
   task automatic drive_styles();
      logic [7:0] cfgT[5] = '{8'h0a, 8'h08, 8'h0c, 8'h0e, 8'h02};
      logic [1:0] onT[5] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h1};
      logic [1:0] offT[5] = '{2'h2, 2'h3, 2'h1, 2'h2, 2'h1};
      wr(IDX_HW_ROUTE, 32'h11);
      for (int i = 0; i < 5; i++) begin
         wr(IDX_PIN_A_CFG, {24'h0, cfgT[i]});
         wr(IDX_PIN_B_CFG, {24'h0, cfgT[i]});
         hwEvt <= 3'h1;
         cyc(4);
         chk({30'h0, aOe, padA}, {30'h0, onT[i]}, "pin A asserted");
         chk({30'h0, bOe, padB}, {30'h0, onT[i]}, "pin B asserted");
         hwEvt <= 3'h0;
         cyc(4);
         chk({30'h0, aOe, padA}, {30'h0, offT[i]}, "pin A idle");
         chk({30'h0, bOe, padB}, {30'h0, offT[i]}, "pin B idle");
      end
      $display("test drive_styles done");
   endtask

   task automatic latch_and_irq();
      wr(IDX_PIN_A_CFG, 32'h0a);
      wr(IDX_PIN_A_ROUTE, 32'h02);
      wr(IDX_HOLD_CFG, 32'h1);
      wr(IDX_EVT_MASK, 32'h2);
      rd(IDX_EVT_STATUS);
      pulse(8'h02);
      cyc(6);
      chk({30'h0, aOut, irqOut}, 32'h3, "latched pin and irq");
      rd(IDX_EVT_STATUS);
      chk(rdv, 32'h2, "status after event");
      cyc(3);
      chk({30'h0, aOut, irqOut}, 32'h0, "cleared by status read");
      wr(IDX_HOLD_CFG, 32'h0);
      pulse(8'h0a);
      cyc(6);
      chk({31'h0, aOut}, 32'h0, "non latched pin");
      rd(IDX_EVT_STATUS);
      chk(rdv, 32'h0a, "status sticky");
      pulse(8'h08);
      cyc(4);
      chk({31'h0, irqOut}, 32'h0, "masked event");
      rd(IDX_EVT_STATUS);
      $display("test latch_and_irq done");
   endtask

   task automatic pin_input();
      wr(IDX_PIN_B_CFG, 32'h12);
      hostDrvB <= 1'b1;
      hostLvlB <= 1'b1;
      cyc(5);
      rd(IDX_EVT_STATUS);
      cyc(5);
      rd(IDX_EVT_STATUS);
      chk(rdv & 32'h1000, 32'h1000, "level trigger repeats");
      wr(IDX_PIN_B_CFG, 32'h13);
      rd(IDX_EVT_STATUS);
      cyc(5);
      rd(IDX_EVT_STATUS);
      chk(rdv & 32'h1000, 32'h0, "edge trigger once");
      hostLvlB <= 1'b0;
      cyc(5);
      hostLvlB <= 1'b1;
      cyc(6);
      rd(IDX_EVT_STATUS);
      chk(rdv & 32'h1000, 32'h1000, "edge trigger on rise");
      wr(IDX_PIN_B_CFG, 32'h02);
      hostLvlB <= 1'b0;
      cyc(5);
      hostLvlB <= 1'b1;
      cyc(6);
      rd(IDX_EVT_STATUS);
      chk(rdv & 32'h1000, 32'h0, "input disabled");
      hostDrvB <= 1'b0;
      wr(IDX_PIN_A_CFG, 32'h12);
      cyc(5);
      rd(IDX_EVT_STATUS);
      chk(rdv & 32'h1800, 32'h0800, "pin A input");
      $display("test pin_input done");
   endtask

   initial begin
      cyc(3);
      sys_rst <= 1'b0;
      reg_access();
      feat_route();
      hw_route();
      drive_styles();
      latch_and_irq();
      pin_input();
      results();
   end

   // Watchdog against a hang outside the bounded bus waits
   initial begin
      cyc(20000);
      badCount++;
      $display("mismatch at %0t: run timed out", $time);
      results();
   end
endmodule
